//--- src/ulfs_pkg.sv
package ulfs_pkg;
  localparam int ULFS_NFLAG = 7;
  localparam logic [7:0] ULFS_OFF_HOLD = 8'h20;
  localparam logic [7:0] ULFS_OFF_MASK = 8'h24;
  localparam logic [7:0] ULFS_OFF_SOF = 8'h28;
  localparam logic [7:0] ULFS_OFF_PID = 8'h2C;
  localparam logic [7:0] ULFS_OFF_EP = 8'h30;
  localparam logic [7:0] ULFS_OFF_EPMARK = 8'h34;
  localparam logic [7:0] ULFS_OFF_PWR = 8'h38;
  localparam logic [7:0] ULFS_OFF_PHY = 8'h3C;
  localparam logic [7:0] ULFS_OFF_FLAGS = 8'h1C;
  localparam int ULFS_MASK1_LSB = 0;
  localparam int ULFS_MASK2_LSB = 8;
  localparam int ULFS_MASK3_LSB = 16;
  localparam int ULFS_EP_VALID_BIT = 4;
  localparam logic [4:0] ULFS_EP_MARK_OR = 5'h10;
  localparam int ULFS_PWR_VALID_BIT = 8;
  localparam int ULFS_PHY_PD_OFF_BIT = 18;
  localparam int ULFS_PHY_SE0_BIT = 13;
  localparam int ULFS_PHY_KRES_BIT = 12;
  localparam int ULFS_PHY_FILT_LSB = 8;
  localparam int ULFS_PHY_AUTO_BIT = 7;
  localparam int ULFS_PHY_CONF_LSB = 4;
  localparam logic [31:0] ULFS_RW_HOLD = 32'h0000007F;
  localparam logic [31:0] ULFS_RW_MASK = 32'h007F7F7F;
  localparam logic [31:0] ULFS_RW_SOF = 32'h000007FF;
  localparam logic [31:0] ULFS_RW_EPMARK = 32'h0000FFFF;
  localparam logic [31:0] ULFS_RW_PWR = 32'h000001FF;
  localparam logic [31:0] ULFS_RW_PHY = 32'h00043FF0;
  localparam logic [31:0] ULFS_ZERO = 32'h00000000;

  typedef struct packed {
    logic en;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } ulfs_req_t;

  typedef struct packed {
    logic pkt_start;
    logic token_ok;
    logic crc16_fail;
    logic rx_active;
    logic rx_error;
    logic [1:0] line_state;
  } ulfs_evt_t;

  typedef struct packed {
    logic pid_valid;
    logic [3:0] pid;
    logic ep_valid;
    logic [3:0] ep;
  } ulfs_pkt_t;
endpackage : ulfs_pkg

//--- src/ulfs_line_filter.sv
`timescale 1ns/1ns
module ulfs_line_filter #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // line
  input wire logic [1:0] line_in,
  input wire logic [3:0] log2_delay,
  output logic [1:0] line_out
);
  import ulfs_pkg::*;
  // elaboration check: the counter must reach two to the fifteenth
  if (CNT_W < 16)
  begin : g_bad_width
    $error("ulfs_line_filter: CNT_W must be at least 16");
  end
  logic [1:0] cand_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] limit;
  logic settle;
  assign limit = CNT_W'(1) << log2_delay;
  assign settle = (cnt_r + CNT_W'(1)) >= limit;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cand_r <= 2'h0;
      cnt_r <= '0;
      line_out <= 2'h0;
    end
    else if (line_in != cand_r)
    begin
      cand_r <= line_in;
      cnt_r <= '0;
    end
    else if (line_out != cand_r)
    begin
      cnt_r <= cnt_r + CNT_W'(1);
      if (settle)
        line_out <= cand_r;
    end
  end
endmodule : ulfs_line_filter

//--- src/ulfs_flag_bit.sv
`timescale 1ns/1ns
module ulfs_flag_bit (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control
  input wire logic hold,
  input wire logic src,
  input wire logic pkt_start,
  input wire logic clr,
  output logic flag
);
  logic flag_nxt;
  // sticky bits keep their value until cleared; set beats clear
  assign flag_nxt = hold ? (src | (flag & ~clr)) : (src | (flag & ~pkt_start));
  always_ff @(posedge clk)
  begin
    if (reset)
      flag <= 1'b0;
    else
      flag <= flag_nxt;
  end
endmodule : ulfs_flag_bit

//--- src/ulfs_top.sv
// How it works
// - sticky flag holds until software writes one
// - non-sticky flag holds until next packet start
// - seven stickiness bits, reset zero
// - third flag port ORs mask bits 22:16
// - second flag port ORs mask bits 14:8
// - first flag port ORs mask bits 6:0
// - 11-bit start-of-frame counter, read-write
// - last received packet identifier, read-only
// - last endpoint copy with valid bit
// - marked endpoints presented ORed with 0x10
// - bit 18 disables byte-port pulldowns
// - se0 auto-resume sets bit 13
// - K auto-resume sets bit 12
// - line-state delay is two to field plus one cycle
// - bit 7 enables suspend controller resume
// - bits 6:4 drive transceiver config pins
// - flag meanings token, lines, crc, rx
// - non-sticky flags clear on next packet
`timescale 1ns/1ns
module ulfs_top #(
  parameter int FILT_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire ulfs_pkg::ulfs_req_t req,
  output logic [31:0] rdata,
  // link events
  input wire ulfs_pkg::ulfs_evt_t evt,
  input wire ulfs_pkg::ulfs_pkt_t pkt,
  input wire logic [10:0] sof_in,
  input wire logic sof_in_valid,
  input wire logic resume_se0,
  input wire logic resume_k,
  // flag ports
  output logic flag_out_first,
  output logic flag_out_second,
  output logic flag_out_third,
  // receive port endpoint
  output logic [4:0] rx_endpoint,
  // transceiver side
  output logic tx_byte_port_pd_en,
  output logic second_byte_port_pd_en,
  output logic [2:0] transceiver_config_pins,
  output logic auto_resume_en,
  output logic [1:0] line_state_filt,
  output logic [7:0] power_data,
  output logic power_valid
);
  import ulfs_pkg::*;
  logic [31:0] hold_r;
  logic [31:0] mask_r;
  logic [31:0] sof_r;
  logic [3:0] pid_r;
  logic [3:0] ep_r;
  logic ep_valid_r;
  logic [31:0] epmark_r;
  logic [31:0] pwr_r;
  logic [31:0] phy_r;
  logic [4:0] rx_ep_r;
  logic [ULFS_NFLAG-1:0] flags;
  logic [ULFS_NFLAG-1:0] src;
  logic [ULFS_NFLAG-1:0] clr;
  logic wr_hold, wr_mask, wr_sof, wr_epmark, wr_pwr, wr_phy, wr_flags;
  logic [31:0] phy_nxt;
  logic [1:0] lf;

  assign wr_hold = req.en & req.wr & (req.addr == ULFS_OFF_HOLD);
  assign wr_mask = req.en & req.wr & (req.addr == ULFS_OFF_MASK);
  assign wr_sof = req.en & req.wr & (req.addr == ULFS_OFF_SOF);
  assign wr_epmark = req.en & req.wr & (req.addr == ULFS_OFF_EPMARK);
  assign wr_pwr = req.en & req.wr & (req.addr == ULFS_OFF_PWR);
  assign wr_phy = req.en & req.wr & (req.addr == ULFS_OFF_PHY);
  assign wr_flags = req.en & req.wr & (req.addr == ULFS_OFF_FLAGS);

  ulfs_line_filter #(
    .CNT_W(FILT_W)
  ) u_filt (
    .clk(clk),
    .reset(reset),
    .line_in(evt.line_state),
    .log2_delay(phy_r[ULFS_PHY_FILT_LSB +: 4]),
    .line_out(lf)
  );
  assign line_state_filt = lf;

  // flag sources: token, se0, K, J, crc16, rx active, rx error
  assign src[6] = evt.token_ok;
  assign src[5] = (lf == 2'h0);
  assign src[4] = (lf == 2'h2);
  assign src[3] = (lf == 2'h1);
  assign src[2] = evt.crc16_fail;
  assign src[1] = evt.rx_active;
  assign src[0] = evt.rx_error;
  assign clr = wr_flags ? req.wdata[ULFS_NFLAG-1:0] : '0;

  genvar gi;
  generate
    for (gi = 0; gi < ULFS_NFLAG; gi++)
    begin : g_flag
      ulfs_flag_bit u_bit (
        .clk(clk),
        .reset(reset),
        .hold(hold_r[gi]),
        .src(src[gi]),
        .pkt_start(evt.pkt_start),
        .clr(clr[gi]),
        .flag(flags[gi])
      );
    end
  endgenerate

  assign flag_out_first = |(flags & mask_r[ULFS_MASK1_LSB +: ULFS_NFLAG]);
  assign flag_out_second = |(flags & mask_r[ULFS_MASK2_LSB +: ULFS_NFLAG]);
  assign flag_out_third = |(flags & mask_r[ULFS_MASK3_LSB +: ULFS_NFLAG]);

  // resume cause bits: hardware set wins over software clear
  always_comb
  begin
    phy_nxt = phy_r;
    if (wr_phy)
      phy_nxt = req.wdata & ULFS_RW_PHY;
    if (resume_se0)
      phy_nxt[ULFS_PHY_SE0_BIT] = 1'b1;
    if (resume_k)
      phy_nxt[ULFS_PHY_KRES_BIT] = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      hold_r <= ULFS_ZERO;
      mask_r <= ULFS_ZERO;
      sof_r <= ULFS_ZERO;
      epmark_r <= ULFS_ZERO;
      pwr_r <= ULFS_ZERO;
      phy_r <= ULFS_ZERO;
    end
    else
    begin
      if (wr_hold)
        hold_r <= req.wdata & ULFS_RW_HOLD;
      if (wr_mask)
        mask_r <= req.wdata & ULFS_RW_MASK;
      if (wr_sof)
        sof_r <= req.wdata & ULFS_RW_SOF;
      else if (sof_in_valid)
        sof_r <= {21'h000000, sof_in};
      if (wr_epmark)
        epmark_r <= req.wdata & ULFS_RW_EPMARK;
      if (wr_pwr)
        pwr_r <= req.wdata & ULFS_RW_PWR;
      phy_r <= phy_nxt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pid_r <= 4'h0;
      ep_r <= 4'h0;
      ep_valid_r <= 1'b0;
      rx_ep_r <= 5'h00;
    end
    else
    begin
      if (pkt.pid_valid)
        pid_r <= pkt.pid;
      if (pkt.ep_valid)
      begin
        ep_r <= pkt.ep;
        ep_valid_r <= 1'b1;
        rx_ep_r <= epmark_r[pkt.ep] ? ({1'b0, pkt.ep} | ULFS_EP_MARK_OR) : {1'b0, pkt.ep};
      end
    end
  end

  assign rx_endpoint = rx_ep_r;
  assign power_data = pwr_r[7:0];
  assign power_valid = pwr_r[ULFS_PWR_VALID_BIT];
  assign tx_byte_port_pd_en = ~phy_r[ULFS_PHY_PD_OFF_BIT];
  assign second_byte_port_pd_en = ~phy_r[ULFS_PHY_PD_OFF_BIT];
  assign auto_resume_en = phy_r[ULFS_PHY_AUTO_BIT];
  assign transceiver_config_pins = phy_r[ULFS_PHY_CONF_LSB +: 3];

  // read mux, unmapped reads zero
  always_comb
  begin
    case (req.addr)
      ULFS_OFF_FLAGS: rdata = {25'h0000000, flags};
      ULFS_OFF_HOLD: rdata = hold_r;
      ULFS_OFF_MASK: rdata = mask_r;
      ULFS_OFF_SOF: rdata = sof_r;
      ULFS_OFF_PID: rdata = {28'h0000000, pid_r};
      ULFS_OFF_EP: rdata = {27'h0000000, ep_valid_r, ep_r};
      ULFS_OFF_EPMARK: rdata = epmark_r;
      ULFS_OFF_PWR: rdata = pwr_r;
      ULFS_OFF_PHY: rdata = phy_r;
      default: rdata = ULFS_ZERO;
    endcase
  end
endmodule : ulfs_top

//--- test/ulfs_phy_model.sv
`timescale 1ns/1ns
module ulfs_phy_model (
  // clock
  input wire logic clk,
  // bench commands
  input wire logic [1:0] line_cmd,
  input wire logic act_cmd,
  input wire logic err_cmd,
  // transceiver pins
  output logic [1:0] line_state,
  output logic rx_active,
  output logic rx_error
);
  // one cycle of transceiver latency on line and receive status
  always_ff @(posedge clk)
  begin
    line_state <= line_cmd;
    rx_active <= act_cmd;
    rx_error <= err_cmd;
  end
endmodule : ulfs_phy_model

//--- test/ulfs_asserts.sv
`timescale 1ns/1ns
module ulfs_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire ulfs_pkg::ulfs_req_t req,
  input wire logic [31:0] rdata,
  // events
  input wire logic resume_se0,
  input wire logic resume_k,
  // outputs
  input wire logic flag_out_first,
  input wire logic flag_out_third,
  input wire logic tx_byte_port_pd_en,
  input wire logic [2:0] transceiver_config_pins,
  input wire logic power_valid
);
  import ulfs_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  wire wr_phy = req.en && req.wr && req.addr == ULFS_OFF_PHY;
  wire wr_pwr = req.en && req.wr && req.addr == ULFS_OFF_PWR;
  pd_bit_a: assert property (wr_phy |=> tx_byte_port_pd_en == !$past(req.wdata[18]))
    else $error("pulldown enable wrong");
  pd_reset_a: assert property ($fell(reset) |-> tx_byte_port_pd_en)
    else $error("pulldown not enabled after reset");
  conf_pins_a: assert property (wr_phy |=> transceiver_config_pins == $past(req.wdata[6:4]))
    else $error("config pins wrong");
  pwr_valid_a: assert property (wr_pwr |=> power_valid == $past(req.wdata[8]))
    else $error("power valid wrong");
  unmapped_zero_a: assert property (req.addr > ULFS_OFF_PHY |-> rdata == 32'h0)
    else $error("unmapped read not zero");
  hold_rsvd_a: assert property (req.addr == ULFS_OFF_HOLD |-> rdata[31:7] == 25'h0)
    else $error("hold reserved bits set");
  se0_sets_a: assert property (resume_se0 ##1 req.addr == ULFS_OFF_PHY |-> rdata[13])
    else $error("se0 resume bit missing");
  k_sets_a: assert property (resume_k ##1 req.addr == ULFS_OFF_PHY |-> rdata[12])
    else $error("k resume bit missing");
  first_mask_a: assert property (req.addr == ULFS_OFF_MASK && rdata[6:0] == 7'h0 |-> !flag_out_first)
    else $error("first port high with empty mask");
  third_mask_a: assert property (req.addr == ULFS_OFF_MASK && rdata[22:16] == 7'h0 |-> !flag_out_third)
    else $error("third port high with empty mask");
  cover property (wr_phy);
  cover property (resume_k);
  cover property (flag_out_third);
endmodule : ulfs_asserts
bind ulfs_top ulfs_asserts ulfs_asserts_i (.clk, .reset, .req, .rdata, .resume_se0, .resume_k, .flag_out_first,
  .flag_out_third, .tx_byte_port_pd_en, .transceiver_config_pins, .power_valid);

//--- test/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import ulfs_pkg::*;
  logic clk, reset, sof_in_valid, resume_se0, resume_k, ps, tok, crc, act, err, acmd, ecmd;
  logic flag_out_first, flag_out_second, flag_out_third, power_valid, auto_resume_en;
  logic tx_byte_port_pd_en, second_byte_port_pd_en;
  logic [1:0] ls, lcmd, line_state_filt;
  logic [2:0] transceiver_config_pins;
  logic [4:0] rx_endpoint;
  logic [7:0] power_data;
  logic [10:0] sof_in;
  logic [31:0] rdata;
  ulfs_req_t req;
  ulfs_evt_t evt;
  ulfs_pkt_t pkt;
  int errors, comparisons;
  logic [7:0] offs [9] = '{8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C, 8'h40};
  logic [31:0] msks [9] = '{ULFS_RW_HOLD, ULFS_RW_MASK, ULFS_RW_SOF, ULFS_ZERO, ULFS_ZERO, ULFS_RW_EPMARK,
    ULFS_RW_PWR, ULFS_RW_PHY, ULFS_ZERO};
  assign evt = {ps, tok, crc, act, err, ls};
  ulfs_top ulfs_top_i (.clk, .reset, .req, .rdata, .evt, .pkt, .sof_in, .sof_in_valid, .resume_se0, .resume_k,
    .flag_out_first, .flag_out_second, .flag_out_third, .rx_endpoint, .tx_byte_port_pd_en,
    .second_byte_port_pd_en, .transceiver_config_pins, .auto_resume_en, .line_state_filt, .power_data,
    .power_valid);
  ulfs_phy_model ulfs_phy_model_i (.clk, .line_cmd(lcmd), .act_cmd(acmd), .err_cmd(ecmd), .line_state(ls),
    .rx_active(act), .rx_error(err));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task wr(input logic [7:0] a, input logic [31:0] d);
    cyc(1);
    req = '{1'b1, 1'b1, a, d};
    cyc(1);
    req.en = 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    cyc(1);
    req = '{1'b1, 1'b0, a, 32'h0};
    #4 chk(rdata, e);
  endtask : rd
  task conclude;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  initial
  begin
    #200000;
    errors++;
    conclude();
  end
  initial
  begin
    reset = 1'b1;
    {sof_in_valid, resume_se0, resume_k, ps, tok, crc, acmd, ecmd} = 8'h00;
    lcmd = 2'h1;
    sof_in = 11'h000;
    pkt = '0;
    req = '0;
    cyc(12);
    reset = 1'b0;
    for (int i = 0; i < 9; i++)
      rd(offs[i], 32'h0);
    chk(32'({tx_byte_port_pd_en, second_byte_port_pd_en}), 32'h3);
    for (int i = 0; i < 9; i++)
    begin
      wr(offs[i], 32'hFFFFFFFF);
      rd(offs[i], msks[i]);
    end
    chk(32'({tx_byte_port_pd_en, second_byte_port_pd_en, transceiver_config_pins, auto_resume_en, power_valid,
      power_data}), 32'h1FFF);
    for (int i = 0; i < 9; i++)
      wr(offs[i], 32'h0);
    wr(ULFS_OFF_PHY, 32'h200);
    lcmd = 2'h2;
    cyc(5);
    chk(32'(line_state_filt), 32'h1);
    cyc(1);
    chk(32'(line_state_filt), 32'h2);
    wr(ULFS_OFF_EPMARK, 32'h20);
    pkt = '{1'b1, 4'hA, 1'b1, 4'h5};
    cyc(1);
    pkt = '0;
    rd(ULFS_OFF_PID, 32'hA);
    rd(ULFS_OFF_EP, 32'h15);
    chk(32'(rx_endpoint), 32'h15);
    cyc(1);
    pkt = '{1'b0, 4'h0, 1'b1, 4'h3};
    cyc(1);
    pkt = '0;
    rd(ULFS_OFF_EP, 32'h13);
    chk(32'(rx_endpoint), 32'h03);
    wr(ULFS_OFF_HOLD, 32'h2);
    wr(ULFS_OFF_MASK, 32'h00440102);
    {acmd, ecmd, tok, crc} = 4'hF;
    cyc(1);
    {acmd, ecmd, tok, crc} = 4'h0;
    cyc(3);
    chk(32'({flag_out_first, flag_out_second, flag_out_third}), 32'h7);
    ps = 1'b1;
    cyc(1);
    ps = 1'b0;
    cyc(1);
    chk(32'({flag_out_first, flag_out_second, flag_out_third}), 32'h4);
    rd(ULFS_OFF_FLAGS, 32'h12);
    wr(ULFS_OFF_FLAGS, 32'h2);
    cyc(1);
    chk(32'(flag_out_first), 32'h0);
    rd(ULFS_OFF_PHY, 32'h200);
    cyc(1);
    resume_se0 = 1'b1;
    cyc(1);
    resume_se0 = 1'b0;
    resume_k = 1'b1;
    cyc(1);
    resume_k = 1'b0;
    rd(ULFS_OFF_PHY, 32'h3200);
    wr(ULFS_OFF_PHY, 32'h0);
    rd(ULFS_OFF_PHY, 32'h0);
    sof_in = 11'h5A5;
    sof_in_valid = 1'b1;
    cyc(1);
    sof_in_valid = 1'b0;
    rd(ULFS_OFF_SOF, 32'h5A5);
    conclude();
  end
endmodule : tb_top
